// ==== include/power_saving_cfg.svh ====
`ifndef POWER_SAVING_CFG_SVH
`define POWER_SAVING_CFG_SVH
`define IRQ_OPTION_ADDR        8'hC8
`define IRQ_OPTION_RESET       8'h00
`define IRQ_OPTION_GEN_BIT     4
`define OSC_STAB_NS            32'h0000_07D0
`define CLK_PERIOD_NS          32'h0000_0032
`define OSC_STAB_CYCLES        ((`OSC_STAB_NS + `CLK_PERIOD_NS - 32'd1) / `CLK_PERIOD_NS)
`endif

// ==== include/power_saving_pkg.sv ====
package power_saving_pkg;
    typedef enum logic [2:0] {
        ST_RUN,
        ST_WAIT,
        ST_STOP,
        ST_STAB,
        ST_RESUME
    } pwr_state_t;
    typedef enum logic [1:0] {
        CTX_MAIN,
        CTX_IRQ,
        CTX_NMI
    } core_ctx_t;
endpackage

// ==== logic/power_saving_mode_control.sv ====
`include "power_saving_cfg.svh"

// Summary of operation
// [RL1] wait halts instructions, peripherals keep running
// [RL2] selected oscillator keeps running in wait
// [RL3] enabled peripheral interrupt ends wait
// [RL4] reset ends wait via normal reset
// [RL5] wake from wait has no delay
// [RL6] stop becomes wait when watchdog active
// [RL7] stop halts oscillator, waits external irq
// [RL8] reset pin ends stop via reset
// [RL9] stop wake waits oscillator stabilisation delay
// [RL10] wake leaves oscillator selection unchanged
// [RL11] main context: service irq then continue
// [RL12] nmi context: continue, stay nmi mode
// [RL13] irq context, maskable wake: resume routine
// [RL14] irq context, nmi wake: nmi first (from stop only; an nmi wake from wait selects no routine)
// [RL15] global enable low: only reset wakes
// [RL16] sleep skipped while enabled irq pending
// [RL17] software enables aux oscillator before wait
// [RL18] write-only option register cleared on reset
// [RL19] wake request gated by global enable
module power_saving_mode_control
    import power_saving_pkg::*;
#(
    parameter int          NUM_IRQ    = 4,
    parameter logic [31:0] STAB_COUNT = `OSC_STAB_CYCLES
) (
    input  wire logic               i_clk,
    input  wire logic               i_resetn,
    input  wire logic               i_wait_exec,
    input  wire logic               i_stop_exec,
    input  wire logic               i_watchdog_active,
    input  wire logic [NUM_IRQ-1:0] i_irq_req,
    input  wire logic [NUM_IRQ-1:0] i_irq_ext,
    input  wire logic               i_nmi_pin,
    input  wire logic               i_nmi_ack,
    input  wire logic               i_in_irq,
    input  wire logic               i_in_nmi,
    input  wire logic               i_opt_wr,
    input  wire logic [7:0]         i_opt_addr,
    input  wire logic [7:0]         i_opt_data,
    input  wire logic               i_low_freq_aux_osc_sel,
    output logic                    o_core_halt,
    output logic                    o_osc_run,
    output logic                    o_low_freq_aux_osc,
    output logic                    o_resume,
    output logic                    o_serve_nmi,
    output logic                    o_serve_irq,
    output logic                    o_global_irq_enable,
    output logic                    o_in_stop
);

    pwr_state_t  state_q, state_d;
    core_ctx_t   ctx_q;
    logic [7:0]  irq_option_reg_q;
    logic [31:0] stab_cnt_q;
    logic        nmi_s1_q, nmi_s2_q, nmi_s3_q, nmi_latch_q;
    logic        nmi_woke_q;
    logic        core_halt_q, osc_run_q, resume_q;
    logic        serve_nmi_q, serve_irq_q, aux_q, in_stop_q;

    // nmi pin is external: two flops, then edge detect on synced copies
    wire nmi_fall = nmi_s3_q & ~nmi_s2_q;
    wire gen      = irq_option_reg_q[`IRQ_OPTION_GEN_BIT];
    wire opt_hit  = i_opt_wr & (i_opt_addr == `IRQ_OPTION_ADDR);
    wire mask_req = gen & (|i_irq_req);
    wire ext_req  = gen & (|i_irq_ext);
    // nmi alone never wakes with gen low
    wire wake_any = mask_req | (gen & nmi_latch_q); // RL19 RL15
    wire wake_stp = ext_req  | (gen & nmi_latch_q); // RL7 RL19
    wire pending  = mask_req | nmi_latch_q;
    wire sleep_rq = (i_wait_exec | i_stop_exec) & ~pending; // RL16
    wire to_stop  = i_stop_exec & ~i_watchdog_active; // RL6
    wire stab_end = (stab_cnt_q == 32'h0000_0001);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (sleep_rq) begin
                    state_d = to_stop ? ST_STOP : ST_WAIT; // RL1 RL6
                end
            end
            ST_WAIT: begin
                if (wake_any) begin
                    state_d = ST_RESUME; // RL3 RL5
                end
            end
            ST_STOP: begin
                if (wake_stp) begin
                    state_d = ST_STAB; // RL9
                end
            end
            ST_STAB: begin
                if (stab_end) begin
                    state_d = ST_RESUME; // RL9
                end
            end
            ST_RESUME: state_d = ST_RUN;
            default:   state_d = ST_RUN;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            nmi_s1_q <= 1'b1;
            nmi_s2_q <= 1'b1;
            nmi_s3_q <= 1'b1;
        end else begin
            nmi_s1_q <= i_nmi_pin;
            nmi_s2_q <= nmi_s1_q;
            nmi_s3_q <= nmi_s2_q;
        end
    end

    // latch set wins over the core's acknowledge
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            nmi_latch_q <= 1'b0;
        end else if (nmi_fall) begin
            nmi_latch_q <= 1'b1;
        end else if (i_nmi_ack) begin
            nmi_latch_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            irq_option_reg_q <= `IRQ_OPTION_RESET; // RL18
        end else if (opt_hit) begin
            irq_option_reg_q <= i_opt_data; // RL18
        end
    end

    // reset is synchronous and overrides any sleep state
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state_q <= ST_RUN; // RL4 RL8
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            ctx_q <= CTX_MAIN;
        end else if (state_q == ST_RUN && sleep_rq) begin
            ctx_q <= i_in_nmi ? CTX_NMI : (i_in_irq ? CTX_IRQ : CTX_MAIN);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            stab_cnt_q <= 32'h0000_0000;
        end else if (state_q == ST_STOP) begin
            stab_cnt_q <= STAB_COUNT; // RL9
        end else if (state_q == ST_STAB && !stab_end) begin
            stab_cnt_q <= stab_cnt_q - 32'h0000_0001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            nmi_woke_q <= 1'b0;
        end else if (state_q == ST_WAIT || state_q == ST_STOP) begin
            nmi_woke_q <= nmi_latch_q;
        end
    end

    // which routine the core runs on resume
    wire sel_nmi = nmi_woke_q & (ctx_q != CTX_NMI); // RL14 RL11
    wire sel_irq = ~nmi_woke_q & (ctx_q == CTX_MAIN); // RL11 RL13 RL12
    wire halt_d  = (state_d != ST_RUN) && (state_d != ST_RESUME); // RL1 RL7

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            core_halt_q <= 1'b0;
            osc_run_q   <= 1'b1;
            resume_q    <= 1'b0;
            serve_nmi_q <= 1'b0;
            serve_irq_q <= 1'b0;
            aux_q       <= 1'b0;
            in_stop_q   <= 1'b0;
        end else begin
            core_halt_q <= halt_d;
            osc_run_q   <= (state_d != ST_STOP); // RL2 RL7
            resume_q    <= (state_d == ST_RESUME);
            serve_nmi_q <= (state_d == ST_RESUME) & sel_nmi; // RL14
            serve_irq_q <= (state_d == ST_RESUME) & sel_irq; // RL11
            aux_q       <= i_low_freq_aux_osc_sel; // RL10 RL17
            in_stop_q   <= (state_d == ST_STOP); // RL7
        end
    end

    assign o_core_halt         = core_halt_q;
    assign o_osc_run           = osc_run_q;
    assign o_low_freq_aux_osc  = aux_q;
    assign o_resume            = resume_q;
    assign o_serve_nmi         = serve_nmi_q;
    assign o_serve_irq         = serve_irq_q;
    assign o_global_irq_enable = irq_option_reg_q[`IRQ_OPTION_GEN_BIT];
    assign o_in_stop           = in_stop_q;

    chk_wait_no_delay: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == ST_WAIT && wake_any |=> state_q == ST_RESUME) // RL5
        else $error("wait wake delayed");
    chk_stop_blocked: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == ST_RUN && i_stop_exec && i_watchdog_active
        |=> state_q != ST_STOP) // RL6
        else $error("stop entered with watchdog");
    chk_no_sleep_pend: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == ST_RUN && pending |=> state_q == ST_RUN) // RL16
        else $error("slept with pending irq");
    chk_gen_low_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == ST_WAIT && !gen |=> state_q == ST_WAIT) // RL15
        else $error("woke with gen low");
    chk_osc_stopped: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == ST_STOP |-> !o_osc_run && o_core_halt) // RL7
        else $error("osc running in stop");
    chk_wait_osc_on: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == ST_WAIT |-> o_osc_run && o_core_halt) // RL2
        else $error("wait state wrong outputs");
    chk_stab_delay: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == ST_STOP && wake_stp |=> state_q == ST_STAB) // RL9
        else $error("stop wake skipped delay");
    chk_nmi_ctx_stay: assert property (@(posedge i_clk) disable iff (!i_resetn)
        resume_q && ctx_q == CTX_NMI |-> !o_serve_nmi && !o_serve_irq) // RL12
        else $error("nmi context left");
    chk_opt_reset: assert property (@(posedge i_clk)
        !i_resetn |=> irq_option_reg_q == 8'h00) // RL18
        else $error("option register not cleared");

    // entry and hold of the sleep states
    chk_wait_entry: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == ST_RUN && sleep_rq && !to_stop |=> state_q == ST_WAIT) // RL1
        else $error("wait not entered");
    chk_stop_entry: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == ST_RUN && sleep_rq && to_stop |=> state_q == ST_STOP) // RL7
        else $error("stop not entered");
    chk_run_no_halt: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == ST_RUN |-> !o_core_halt) // RL1
        else $error("core halted in run");
    chk_run_no_stab: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == ST_RUN |=> state_q != ST_STAB && state_q != ST_RESUME) // RL1
        else $error("run left without sleep");
    chk_wait_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == ST_WAIT && !wake_any |=> state_q == ST_WAIT) // RL3
        else $error("wait left without wake");
    chk_wait_no_stab: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == ST_WAIT |=> state_q != ST_STAB) // RL5
        else $error("wait wake went through delay");
    chk_stop_needs_irq: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == ST_STOP && !wake_stp |=> state_q == ST_STOP) // RL7
        else $error("stop left without wake");
    chk_gen_low_stop: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == ST_STOP && !gen |=> state_q == ST_STOP) // RL15
        else $error("stop woke with gen low");
    chk_in_stop_flag: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == ST_STOP |-> o_in_stop) // RL7
        else $error("stop flag missing");

    // stabilisation count after a stop wake
    chk_stab_load: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == ST_STOP && wake_stp |=> stab_cnt_q == STAB_COUNT) // RL9
        else $error("stabilisation count not loaded");
    chk_stab_min: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == ST_STAB && !stab_end |=> state_q == ST_STAB) // RL9
        else $error("stabilisation cut short");
    chk_stab_exit: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == ST_STAB && stab_end |=> state_q == ST_RESUME) // RL9
        else $error("stabilisation overran");
    chk_halt_in_stab: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == ST_STAB |-> o_core_halt && o_osc_run) // RL9
        else $error("stabilisation outputs wrong");

    // resume pulse and routine selection
    chk_resume_out: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == ST_RESUME |-> !o_core_halt && o_resume) // RL5
        else $error("resume outputs wrong");
    chk_resume_one: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_resume |=> !o_resume) // RL11
        else $error("resume longer than one cycle");
    chk_serve_excl: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !(o_serve_nmi && o_serve_irq)) // RL14
        else $error("both routines selected");
    chk_serve_resume: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_serve_nmi || o_serve_irq |-> o_resume) // RL11
        else $error("routine selected without resume");
    chk_main_irq: assert property (@(posedge i_clk) disable iff (!i_resetn)
        resume_q && ctx_q == CTX_MAIN && !nmi_woke_q |-> o_serve_irq) // RL11
        else $error("main context irq not served");
    chk_nmi_first: assert property (@(posedge i_clk) disable iff (!i_resetn)
        resume_q && ctx_q == CTX_IRQ && nmi_woke_q |-> o_serve_nmi) // RL14
        else $error("nmi not served first");
    chk_ctx_nmi: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == ST_RUN && sleep_rq && i_in_nmi |=> ctx_q == CTX_NMI) // RL12
        else $error("nmi context not kept");
    chk_ctx_irq: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == ST_RUN && sleep_rq && !i_in_nmi && i_in_irq
        |=> ctx_q == CTX_IRQ) // RL13
        else $error("irq context not kept");

    // oscillator selection and option register
    chk_aux_follow: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_resetn |=> o_low_freq_aux_osc == $past(i_low_freq_aux_osc_sel)) // RL10
        else $error("oscillator selection changed");
    chk_opt_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
        opt_hit |=> irq_option_reg_q == $past(i_opt_data)) // RL18
        else $error("option write lost");

endmodule // power_saving_mode_control

// ==== test/core_model.sv ====
module core_model (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_serve_nmi,
    output logic      o_nmi_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    // routine opens one cycle after the call; its acknowledge clears the latch one cycle later
    always_ff @(posedge i_clk) begin
        if (!i_resetn)
            o_nmi_ack <= 1'b0;
        else
            o_nmi_ack <= i_serve_nmi;
    end
endmodule // core_model

// ==== test/tb.sv ====
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       i_clk = 0, i_resetn = 0, i_wait_exec = 0, i_stop_exec = 0;
    logic       i_watchdog_active = 0, i_nmi_pin = 1, i_in_irq = 0;
    logic       i_in_nmi = 0, i_opt_wr = 0, i_low_freq_aux_osc_sel = 0;
    logic [3:0] i_irq_req = 4'h0, i_irq_ext = 4'h0;
    logic [7:0] i_opt_addr = 8'h00, i_opt_data = 8'h00;
    logic       i_nmi_ack, o_core_halt, o_osc_run, o_low_freq_aux_osc;
    logic       o_resume, o_serve_nmi, o_serve_irq, o_global_irq_enable;
    logic       o_in_stop;
    int         mismatches = 0, total_checks = 0, n;
    always #25 i_clk = ~i_clk;
    power_saving_mode_control #(.NUM_IRQ(4), .STAB_COUNT(32'h0000_0003))
        power_saving_mode_control_i (.i_clk, .i_resetn, .i_wait_exec,
        .i_stop_exec, .i_watchdog_active, .i_irq_req, .i_irq_ext, .i_nmi_pin,
        .i_nmi_ack, .i_in_irq, .i_in_nmi, .i_opt_wr, .i_opt_addr, .i_opt_data,
        .i_low_freq_aux_osc_sel, .o_core_halt, .o_osc_run,
        .o_low_freq_aux_osc, .o_resume, .o_serve_nmi, .o_serve_irq,
        .o_global_irq_enable, .o_in_stop);
    core_model core_model_i (.i_clk, .i_resetn, .i_serve_nmi(o_serve_nmi),
        .o_nmi_ack(i_nmi_ack));
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task cyc(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask
    task rst(input int k);
        i_resetn = 0;
        cyc(k);
        i_resetn = 1;
    endtask
    task opt(input logic [7:0] a, input logic [7:0] d);
        i_opt_wr = 1;
        i_opt_addr = a;
        i_opt_data = d;
        cyc(1);
        i_opt_wr = 0;
        cyc(1);
    endtask
    task sleep(input logic stp);
        i_stop_exec = stp;
        i_wait_exec = !stp;
        cyc(1);
        i_stop_exec = 0;
        i_wait_exec = 0;
        cyc(2);
    endtask
    // bounded: a missing resume ends the run as a mismatch
    task wake;
        n = 0;
        while (o_resume !== 1'b1 && n < 60) begin
            cyc(1);
            n++;
        end
        if (n == 60) begin
            mismatches++;
            end_sim;
        end
    endtask
    task clr;
        i_irq_req = 4'h0;
        i_irq_ext = 4'h0;
        i_nmi_pin = 1;
        cyc(3);
    endtask
    task t_reg;
        `CHK(o_global_irq_enable, 1'b0)
        `CHK({o_core_halt, o_osc_run, o_in_stop}, 3'h2)
        opt(8'hC9, 8'h10);
        `CHK(o_global_irq_enable, 1'b0)
        opt(8'hC8, 8'h10);
        `CHK(o_global_irq_enable, 1'b1)
        $display("test reg done");
    endtask
    task t_wait;
        i_low_freq_aux_osc_sel = 1;
        sleep(0);
        `CHK(o_core_halt, 1'b1)
        `CHK(o_osc_run, 1'b1)
        i_irq_req = 4'h8;
        wake;
        `CHK(n <= 3, 1'b1)
        `CHK({o_serve_irq, o_serve_nmi}, 2'h2)
        clr;
        `CHK(o_core_halt, 1'b0)
        $display("test wait done");
    endtask
    task t_stop;
        sleep(1);
        `CHK({o_osc_run, o_in_stop}, 2'h1)
        i_irq_req = 4'h8;
        cyc(6);
        `CHK(o_core_halt, 1'b1)
        i_irq_req = 4'h9;
        i_irq_ext = 4'h1;
        wake;
        `CHK(n > 3, 1'b1)
        `CHK(o_low_freq_aux_osc, 1'b1)
        clr;
        `CHK(o_osc_run, 1'b1)
        i_watchdog_active = 1;
        sleep(1);
        `CHK({o_core_halt, o_osc_run, o_in_stop}, 3'h6)
        i_irq_req = 4'h2;
        wake;
        clr;
        i_watchdog_active = 0;
        $display("test stop done");
    endtask
    task t_ctx;
        i_irq_req = 4'h1;
        sleep(0);
        `CHK(o_core_halt, 1'b0)
        sleep(1);
        `CHK(o_core_halt, 1'b0)
        clr;
        i_in_nmi = 1;
        sleep(0);
        i_irq_req = 4'h1;
        wake;
        `CHK({o_serve_irq, o_serve_nmi}, 2'h0)
        clr;
        i_in_nmi = 0;
        i_in_irq = 1;
        sleep(0);
        i_irq_req = 4'h4;
        wake;
        `CHK({o_serve_irq, o_serve_nmi}, 2'h0)
        clr;
        sleep(1);
        i_nmi_pin = 0;
        wake;
        `CHK({o_serve_irq, o_serve_nmi}, 2'h1)
        clr;
        i_in_irq = 0;
        $display("test ctx done");
    endtask
    task t_gen;
        opt(8'hC8, 8'h00);
        sleep(0);
        i_irq_req = 4'h1;
        i_nmi_pin = 0;
        cyc(8);
        `CHK(o_core_halt, 1'b1)
        `CHK(o_global_irq_enable, 1'b0)
        rst(1);
        clr;
        `CHK(o_core_halt, 1'b0)
        sleep(1);
        `CHK(o_in_stop, 1'b1)
        rst(1);
        cyc(1);
        `CHK({o_core_halt, o_osc_run, o_in_stop}, 3'h2)
        $display("test gen done");
    endtask
    initial begin
        rst(10);
        t_reg;
        t_wait;
        t_stop;
        t_ctx;
        t_gen;
        end_sim;
    end
endmodule // tb
